// [rbse_pkg.sv]
// shared constants and types for the relative branch / bit set execution block
// assumes a 250 MHz core clock with four clocks forming one instruction cycle
`default_nettype none

package rbse_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses, one aligned word each)
	// ------------------------------------------------------------
	localparam logic [7:0]  OFF_CTRL        = 8'h00;
	localparam logic [7:0]  OFF_BANK        = 8'h04;
	localparam logic [7:0]  OFF_STATUS      = 8'h08;
	localparam logic [7:0]  OFF_JUMPS       = 8'h0c;
	localparam logic        CTRL_EN_RST     = 1'b1;
	localparam logic [3:0]  BANK_RST        = 4'h0;
	localparam int unsigned CTRL_EN_BIT     = 0;
	localparam int unsigned STAT_PHASE_LSB  = 0;
	localparam int unsigned STAT_NOP_BIT    = 2;
	localparam int unsigned STAT_OP_LSB     = 4;
	localparam logic [1:0]  AXI_OKAY        = 2'b00;
	localparam logic [1:0]  AXI_SLVERR      = 2'b10;

	// ------------------------------------------------------------
	// instruction encodings and fields
	// ------------------------------------------------------------
	localparam logic [4:0]  JUMP_OPC        = 5'h1a;
	localparam logic [3:0]  BITSET_OPC      = 4'h8;
	localparam logic [7:0]  NZJUMP_OPC      = 8'he1;
	localparam int unsigned JUMP_OFF_W      = 11;
	localparam int unsigned SHORT_OFF_W     = 8;
	localparam int unsigned BIT_IDX_LSB     = 9;
	localparam int unsigned BANK_SEL_BIT    = 8;
	localparam logic [7:0]  ACCESS_SPLIT    = 8'h80;
	localparam logic [3:0]  ACCESS_LO_BANK  = 4'h0;
	localparam logic [3:0]  ACCESS_HI_BANK  = 4'hf;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		Q1 = 2'b00,
		Q2 = 2'b01,
		Q3 = 2'b11,
		Q4 = 2'b10
	} rbse_phase_t;

	typedef enum logic [1:0] {
		OP_NONE   = 2'h0,
		OP_JUMP   = 2'h1,
		OP_BITSET = 2'h2,
		OP_NZJUMP = 2'h3
	} rbse_op_t;

	typedef struct packed {
		logic [11:0] addr;
		logic [7:0]  data;
	} rbse_rf_wr_t;

endpackage : rbse_pkg

`default_nettype wire

// [rbse_exec.sv]
// execution of relative jumps, bit set and the branch on non-zero result
// assumes fetch presents a word and its incremented pc, register file reads combinationally
// Behaviour
// [RULE1] upper five bits 11010 mark the unconditional jump with eleven offset bits
// [RULE2] the eleven-bit jump offset is signed, -1024 to 1023
// [RULE3] target is incremented pc plus twice the signed offset
// [RULE4] jump: one word, two cycles, pc written in Q4, second cycle idle
// [RULE5] top nibble 1000 marks bit set: bit index, bank bit, register address
// [RULE6] bit set forces the chosen bit to one, other bits and flags untouched
// [RULE7] bank bit 0 uses the fixed access bank, ignoring the bank pointer
// [RULE8] bank bit 1 takes the bank from the bank select pointer
// [RULE9] bit set: decode Q1, read Q2, modify Q3, write back Q4
// [RULE10] untaken non-zero branch finishes in one cycle without pc write
// [RULE11] a taken branch discards the prefetched word; extra cycle is a no-op
`default_nettype none

module rbse_exec #(
	parameter int unsigned PC_W = 21
) (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic [15:0]          instr_word,
	input  wire logic                 instr_valid,
	output logic                      instr_ready,
	input  wire logic [PC_W-1:0]      pc_in,
	input  wire logic                 result_zero,
	output logic                      rf_rd_en,
	output logic [11:0]               rf_rd_addr,
	input  wire logic [7:0]           rf_rd_data,
	output logic                      rf_wr_en,
	output rbse_pkg::rbse_rf_wr_t     rf_wr,
	output logic                      pc_wr_en,
	output logic [PC_W-1:0]           pc_wr_value,
	output logic                      prefetch_flush,
	output rbse_pkg::rbse_phase_t     phase
);
	import rbse_pkg::*;

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	function automatic rbse_op_t classify(input logic [15:0] w);
		rbse_op_t op;
		op = OP_NONE;
		if (w[15:11] == JUMP_OPC) begin
			op = OP_JUMP; // [RULE1]
		end else if (w[15:12] == BITSET_OPC) begin
			op = OP_BITSET; // [RULE5]
		end else if (w[15:8] == NZJUMP_OPC) begin
			op = OP_NZJUMP;
		end
		return op;
	endfunction : classify

	function automatic logic [11:0] form_addr(input logic [15:0] w, input logic [3:0] bank);
		logic [3:0] b;
		b = bank; // [RULE8]
		if (!w[BANK_SEL_BIT]) begin
			b = (w[7:0] < ACCESS_SPLIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK; // [RULE7]
		end
		return {b, w[7:0]};
	endfunction : form_addr

	// twice the signed offset, sign extended to the pc width
	function automatic logic [PC_W-1:0] rel_offset(input logic [15:0] w, input rbse_op_t op);
		logic signed [PC_W-1:0] o;
		o = '0;
		if (op == OP_JUMP) begin
			o = PC_W'($signed(w[JUMP_OFF_W-1:0])); // [RULE2]
		end else begin
			o = PC_W'($signed(w[SHORT_OFF_W-1:0]));
		end
		return PC_W'(o <<< 1);
	endfunction : rel_offset

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	rbse_phase_t     phase_reg,    phase_next;
	rbse_op_t        op_reg,       op_next;
	logic [15:0]     word_reg,     word_next;
	logic [PC_W-1:0] base_reg,     base_next;
	logic [PC_W-1:0] target_reg,   target_next;
	logic [7:0]      data_reg,     data_next;
	logic            taken_reg,    taken_next;
	logic            nop_reg,      nop_next;
	logic            rd_en_reg,    rd_en_next;
	logic [11:0]     rd_addr_reg,  rd_addr_next;
	logic            wr_en_reg,    wr_en_next;
	rbse_rf_wr_t     wr_reg,       wr_next;
	logic            pcw_reg,      pcw_next;
	logic            flush_reg,    flush_next;
	logic            en_reg,       en_next;
	logic [3:0]      bank_reg,     bank_next;
	logic [31:0]     jumps_reg,    jumps_next;
	logic            aw_hold_reg,  aw_hold_next;
	logic [7:0]      aw_addr_reg,  aw_addr_next;
	logic            w_hold_reg,   w_hold_next;
	logic [31:0]     w_data_reg,   w_data_next;
	logic [3:0]      w_strb_reg,   w_strb_next;
	logic            bvalid_reg,   bvalid_next;
	logic [1:0]      bresp_reg,    bresp_next;
	logic            rvalid_reg,   rvalid_next;
	logic [31:0]     rdata_reg,    rdata_next;
	logic [1:0]      rresp_reg,    rresp_next;
	rbse_op_t        dec_op;

	assign instr_ready    = (phase_reg == Q1) && !nop_reg; // [RULE11]
	assign dec_op         = en_reg ? classify(instr_word) : OP_NONE;
	assign rf_rd_en       = rd_en_reg;
	assign rf_rd_addr     = rd_addr_reg;
	assign rf_wr_en       = wr_en_reg;
	assign rf_wr          = wr_reg;
	assign pc_wr_en       = pcw_reg;
	assign pc_wr_value    = target_reg;
	assign prefetch_flush = flush_reg;
	assign phase          = phase_reg;

	// ------------------------------------------------------------
	// quarter-cycle sequencing
	// ------------------------------------------------------------
	always_comb begin
		phase_next   = phase_reg;
		op_next      = op_reg;
		word_next    = word_reg;
		base_next    = base_reg;
		target_next  = target_reg;
		data_next    = data_reg;
		taken_next   = taken_reg;
		nop_next     = nop_reg;
		rd_en_next   = 1'b0;
		rd_addr_next = rd_addr_reg;
		wr_en_next   = 1'b0;
		wr_next      = wr_reg;
		pcw_next     = 1'b0;
		flush_next   = 1'b0;
		jumps_next   = jumps_reg;
		unique case (phase_reg)
			Q1: begin
				phase_next = Q2;
				op_next    = OP_NONE;
				// idle cycle after a taken branch takes no word
				if (instr_valid && instr_ready) begin
					op_next      = dec_op;
					word_next    = instr_word;
					base_next    = pc_in;
					rd_addr_next = form_addr(instr_word, bank_reg);
					rd_en_next   = (dec_op == OP_BITSET); // [RULE9]
				end
			end
			Q2: begin
				phase_next = Q3;
				if (op_reg == OP_BITSET) begin
					data_next = rf_rd_data; // [RULE9]
				end
			end
			Q3: begin
				phase_next  = Q4;
				data_next   = data_reg | (8'h01 << word_reg[BIT_IDX_LSB +: 3]); // [RULE6]
				target_next = base_reg + rel_offset(word_reg, op_reg); // [RULE3]
				taken_next  = (op_reg == OP_JUMP) ||
				              ((op_reg == OP_NZJUMP) && !result_zero); // [RULE10]
				wr_en_next  = (op_reg == OP_BITSET); // [RULE9]
				wr_next     = '{addr: rd_addr_reg, data: data_next};
				pcw_next    = taken_next; // [RULE4]
				flush_next  = taken_next; // [RULE11]
			end
			Q4: begin
				phase_next = Q1;
				nop_next   = taken_reg; // [RULE4]
				taken_next = 1'b0;
				op_next    = OP_NONE;
				if (taken_reg) begin
					jumps_next = jumps_reg + 32'h1;
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_reg   <= Q1;
			op_reg      <= OP_NONE;
			word_reg    <= 16'h0;
			base_reg    <= '0;
			target_reg  <= '0;
			data_reg    <= 8'h0;
			taken_reg   <= 1'b0;
			nop_reg     <= 1'b0;
			rd_en_reg   <= 1'b0;
			rd_addr_reg <= 12'h0;
			wr_en_reg   <= 1'b0;
			wr_reg      <= '0;
			pcw_reg     <= 1'b0;
			flush_reg   <= 1'b0;
			jumps_reg   <= 32'h0;
		end else begin
			phase_reg   <= phase_next;
			op_reg      <= op_next;
			word_reg    <= word_next;
			base_reg    <= base_next;
			target_reg  <= target_next;
			data_reg    <= data_next;
			taken_reg   <= taken_next;
			nop_reg     <= nop_next;
			rd_en_reg   <= rd_en_next;
			rd_addr_reg <= rd_addr_next;
			wr_en_reg   <= wr_en_next;
			wr_reg      <= wr_next;
			pcw_reg     <= pcw_next;
			flush_reg   <= flush_next;
			jumps_reg   <= jumps_next;
		end
	end

	// ------------------------------------------------------------
	// axi4-lite slave
	// ------------------------------------------------------------
	assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
	assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	always_comb begin
		aw_hold_next = aw_hold_reg;
		aw_addr_next = aw_addr_reg;
		w_hold_next  = w_hold_reg;
		w_data_next  = w_data_reg;
		w_strb_next  = w_strb_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		rvalid_next  = rvalid_reg;
		rdata_next   = rdata_reg;
		rresp_next   = rresp_reg;
		en_next      = en_reg;
		bank_next    = bank_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_next = 1'b1;
			aw_addr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_hold_next = 1'b1;
			w_data_next = s_axi_wdata;
			w_strb_next = s_axi_wstrb;
		end
		if (aw_hold_reg && w_hold_reg) begin
			aw_hold_next = 1'b0;
			w_hold_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = AXI_OKAY;
			// only the low byte lane carries writable bits
			unique case (aw_addr_reg)
				OFF_CTRL: begin
					if (w_strb_reg[0]) en_next = w_data_reg[CTRL_EN_BIT];
				end
				OFF_BANK: begin
					if (w_strb_reg[0]) bank_next = w_data_reg[3:0];
				end
				OFF_STATUS, OFF_JUMPS: begin
				end
				default: bresp_next = AXI_SLVERR;
			endcase
		end
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_next = 1'b1;
			rresp_next  = AXI_OKAY;
			rdata_next  = 32'h0;
			unique case (s_axi_araddr)
				OFF_CTRL:   rdata_next[CTRL_EN_BIT] = en_reg;
				OFF_BANK:   rdata_next[3:0] = bank_reg;
				OFF_STATUS: begin
					rdata_next[STAT_PHASE_LSB +: 2] = phase_reg;
					rdata_next[STAT_NOP_BIT]        = nop_reg;
					rdata_next[STAT_OP_LSB +: 2]    = op_reg;
				end
				OFF_JUMPS:  rdata_next = jumps_reg;
				default:    rresp_next = AXI_SLVERR;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg <= 1'b0;
			aw_addr_reg <= 8'h0;
			w_hold_reg  <= 1'b0;
			w_data_reg  <= 32'h0;
			w_strb_reg  <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= AXI_OKAY;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0;
			rresp_reg   <= AXI_OKAY;
			en_reg      <= CTRL_EN_RST;
			bank_reg    <= BANK_RST;
		end else begin
			aw_hold_reg <= aw_hold_next;
			aw_addr_reg <= aw_addr_next;
			w_hold_reg  <= w_hold_next;
			w_data_reg  <= w_data_next;
			w_strb_reg  <= w_strb_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			rvalid_reg  <= rvalid_next;
			rdata_reg   <= rdata_next;
			rresp_reg   <= rresp_next;
			en_reg      <= en_next;
			bank_reg    <= bank_next;
		end
	end

endmodule : rbse_exec

`default_nettype wire

// [rbse_exec_checker.sv]
// port checks for the execution block
// assumes the shared package; bound into every block instance
`default_nettype none

module rbse_exec_checker #(
	parameter int unsigned PC_W = 21
) (
	input wire logic                  aclk,
	input wire logic                  aresetn,
	input wire logic [15:0]           instr_word,
	input wire logic                  instr_valid,
	input wire logic                  instr_ready,
	input wire logic [PC_W-1:0]       pc_in,
	input wire logic                  result_zero,
	input wire logic                  rf_rd_en,
	input wire logic [11:0]           rf_rd_addr,
	input wire logic [7:0]            rf_rd_data,
	input wire logic                  rf_wr_en,
	input wire rbse_pkg::rbse_rf_wr_t rf_wr,
	input wire logic                  pc_wr_en,
	input wire logic [PC_W-1:0]       pc_wr_value,
	input wire logic                  prefetch_flush,
	input wire rbse_pkg::rbse_phase_t phase
);
	timeunit 1ns;
	timeprecision 1ps;
	import rbse_pkg::*;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic [15:0]     w_q;
	logic [PC_W-1:0] p_q;
	logic            take;
	logic [PC_W-1:0] j_off;
	logic [PC_W-1:0] b_off;
	assign take = phase == Q1 && instr_valid && instr_ready;
	assign j_off = {{(PC_W-11){w_q[10]}}, w_q[9:0], 1'b0};
	assign b_off = {{(PC_W-8){w_q[7]}}, w_q[6:0], 1'b0};
	// word and pc kept so later phases can be judged against them
	always_ff @(posedge aclk) begin
		if (take) begin
			w_q <= instr_word;
			p_q <= pc_in;
		end
	end

	sequence s_cycle; phase == Q1 ##1 phase == Q2 ##1 phase == Q3 ##1 phase == Q4; endsequence
	sequence s_nzjump; take && instr_word[15:8] == NZJUMP_OPC ##2 1'b1; endsequence
	property p_phase; phase == Q1 |-> s_cycle; endproperty
	property p_jump; take && instr_word[15:11] == 5'h1a |->
		##3 pc_wr_en && pc_wr_value == p_q + j_off; endproperty
	property p_bset; take && instr_word[15:12] == 4'h8 |-> ##1 rf_rd_en ##2 rf_wr_en; endproperty
	property p_rd; rf_rd_en |-> phase == Q2 && rf_rd_addr[7:0] == w_q[7:0] &&
		(w_q[8] || rf_rd_addr[11:8] == (w_q[7] ? 4'hf : 4'h0)); endproperty
	property p_wr; rf_wr_en |-> phase == Q4 && rf_wr.addr == rf_rd_addr &&
		rf_wr.data == ($past(rf_rd_data, 2) | (8'h01 << w_q[11:9])); endproperty
	property p_flush; pc_wr_en || prefetch_flush |-> pc_wr_en && prefetch_flush && phase == Q4;
	endproperty
	property p_idle; pc_wr_en |=> !instr_ready [*4] ##1 instr_ready; endproperty
	property p_nz_taken; s_nzjump ##0 !result_zero |-> ##1 pc_wr_en && pc_wr_value == p_q + b_off;
	endproperty
	property p_nz_untaken; s_nzjump ##0 result_zero |-> ##1 !pc_wr_en; endproperty

	a_phase: assert property (p_phase) else $error("phase order broken");
	a_jump: assert property (p_jump) else $error("jump target wrong");
	a_bset: assert property (p_bset) else $error("bit set timing wrong");
	a_rd: assert property (p_rd) else $error("bit set address wrong");
	a_wr: assert property (p_wr) else $error("bit set data wrong");
	a_flush: assert property (p_flush) else $error("flush not with pc write");
	a_idle: assert property (p_idle) else $error("idle cycle missing");
	a_nz_taken: assert property (p_nz_taken) else $error("taken branch wrong");
	a_nz_untaken: assert property (p_nz_untaken) else $error("untaken branch wrote pc");
endmodule : rbse_exec_checker

bind rbse_exec rbse_exec_checker #(.PC_W(PC_W)) u_chk (.*);

`default_nettype wire

// [rbse_rf_model.sv]
// banked register file model facing the execution block
// assumes combinational reads and writes landing at the edge
`default_nettype none

module rbse_rf_model (
	input  wire logic                  aclk,
	input  wire logic                  rf_rd_en,
	input  wire logic [11:0]           rf_rd_addr,
	output logic      [7:0]            rf_rd_data,
	input  wire logic                  rf_wr_en,
	input  wire rbse_pkg::rbse_rf_wr_t rf_wr
);
	timeunit 1ns;
	timeprecision 1ps;
	import rbse_pkg::*;
	logic [7:0] mem [4096];
	// outside a read the lines show the inverse, so a late sample is caught
	assign rf_rd_data = rf_rd_en ? mem[rf_rd_addr] : ~mem[rf_rd_addr];
	always @(posedge aclk) begin
		if (rf_wr_en) begin
			mem[rf_wr.addr] <= rf_wr.data;
		end
	end
endmodule : rbse_rf_model

`default_nettype wire

// [testbench.sv]
// self-checking bench: register bus, jumps, bit sets, non-zero branch
// assumes the package, the block, its checker and the model compile first
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
	$display("Error %s expected %0h seen %0h", n, e, g); end end

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import rbse_pkg::*;
	localparam int unsigned PW = 21;
	logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_arvalid = '0;
	logic s_axi_bready = '1, s_axi_rready = '1, instr_valid = '0, result_zero = '0, pw, ww;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic instr_ready, rf_rd_en, rf_wr_en, pc_wr_en, prefetch_flush;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, rf_rd_data, f;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] instr_word = '0;
	logic [PW-1:0] pc_in = '0, pc_wr_value, exp_pc;
	logic [11:0] rf_rd_addr, ad, alt;
	logic [10:0] joff [4] = '{11'h3ff, 11'h400, 11'h000, 11'h7ff};
	rbse_rf_wr_t rf_wr;
	rbse_phase_t phase;
	int fail_count = 0, compares = 0, cyc = 0;

	rbse_exec #(.PC_W(PW)) DUT (.*);
	rbse_rf_model mdl (.*);

	always #2 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			final_report();
		end
	end

	task automatic final_report;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report

	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		`CHK("bresp", er, s_axi_bresp)
	endtask : axw

	task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		`CHK("rdata", ed, s_axi_rdata)
		`CHK("rresp", er, s_axi_rresp)
	endtask : axr

	// offers a word in the next Q1, then watches that instruction cycle
	task automatic run(input logic [15:0] w, input logic [PW-1:0] p, input logic z);
		while (phase !== Q4) @(posedge aclk);
		instr_word <= w;
		pc_in <= p;
		result_zero <= z;
		instr_valid <= 1'b1;
		@(posedge aclk);
		instr_valid <= 1'b0;
		pw = 1'b0;
		ww = 1'b0;
		repeat (3) begin
			@(posedge aclk);
			pw |= pc_wr_en;
			ww |= rf_wr_en;
		end
	endtask : run

	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		axr(OFF_CTRL, 32'h1, AXI_OKAY);
		axr(OFF_BANK, 32'h0, AXI_OKAY);
		axr(8'h10, 32'h0, AXI_SLVERR);
		axw(8'h10, 32'hff, AXI_SLVERR);
		axw(OFF_BANK, 32'h5, AXI_OKAY);
		axr(OFF_BANK, 32'h5, AXI_OKAY);
		// a write without byte lane 0 must leave the bank pointer alone
		s_axi_wstrb <= 4'he;
		axw(OFF_BANK, 32'h3, AXI_OKAY);
		s_axi_wstrb <= 4'hf;
		axr(OFF_BANK, 32'h5, AXI_OKAY);
		mdl.mem[12'h020] = 8'h00;
		foreach (joff[i]) begin
			run({5'h1a, joff[i]}, 21'h01000, 1'b0);
			`CHK("jump pc write", 1'b1, pw)
			exp_pc = 21'h01000 + {{(PW-11){joff[i][10]}}, joff[i][9:0], 1'b0};
			`CHK("jump target", exp_pc, pc_wr_value)
			// word offered in the idle cycle must be dropped
			run(16'h8020, 21'h0, 1'b0);
			`CHK("idle write", 1'b0, ww)
		end
		for (int b = 0; b < 8; b++) begin
			f = b[1] ? 8'h90 : 8'h10;
			ad = {b[0] ? 4'h5 : (f[7] ? 4'hf : 4'h0), f};
			alt = {b[0] ? (f[7] ? 4'hf : 4'h0) : 4'h5, f};
			mdl.mem[ad] = 8'h24;
			mdl.mem[alt] = 8'h00;
			run({4'h8, b[2:0], b[0], f}, 21'h0, 1'b0);
			@(posedge aclk);
			`CHK("bit set", 8'h24 | (8'h01 << b), mdl.mem[ad])
			`CHK("other bank", 8'h00, mdl.mem[alt])
		end
		run(16'he180, 21'h02000, 1'b1);
		`CHK("nz branch untaken", 1'b0, pw)
		run(16'he180, 21'h02000, 1'b0);
		`CHK("nz branch taken", 1'b1, pw)
		`CHK("nz branch target", 21'h01f00, pc_wr_value)
		axr(OFF_JUMPS, 32'h5, AXI_OKAY);
		`CHK("idle reg", 8'h00, mdl.mem[12'h020])
		final_report();
	end
endmodule : testbench

`default_nettype wire
